// ---- verif/csbu_top_props.sv ----
// csbu_top_props: result and timing checks for the compare / skip / branch unit.
// assumes it is bound to csbu_top and sees only that module's ports.
`default_nettype none
module csbu_top_props
    import csbu_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // watched ports
    input wire logic req_valid_i,
    input wire csbu_pkg::csbu_req_t req_i,
    input wire logic ready_o,
    input wire csbu_pkg::csbu_res_t res_o,
    input wire logic [csbu_pkg::DATA_W-1:0] flags_o,
    input wire csbu_pkg::csbu_apb_req_t apb_i,
    input wire csbu_pkg::csbu_apb_rsp_t apb_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic acc = req_valid_i && ready_o;
    wire logic is_cmp = req_i.op <= OP_CMP_IMM;
    wire logic nv = flags_o[FLG_N] ^ flags_o[FLG_V];

    cmp_one_cycle_a: assert property (acc && is_cmp |=>
        res_o.done && ready_o && res_o.pc_next == $past(req_i.pc) + 16'h0001) else $error("compare late");
    cmp_zero_a: assert property (acc && req_i.op == OP_CMP |=>
        flags_o[FLG_Z] == ($past(req_i.rd) == $past(req_i.opnd))) else $error("compare zero flag wrong");
    eq_taken_a: assert property (acc && req_i.op == OP_BRANCH_EQUAL && flags_o[FLG_Z] |=>
        !ready_o && !res_o.done ##1 res_o.done && res_o.pc_load && res_o.taken) else $error("equal branch");
    ne_fall_a: assert property (acc && req_i.op == OP_BRANCH_NOT_EQUAL && flags_o[FLG_Z] |=>
        res_o.done && !res_o.taken && res_o.pc_next == $past(req_i.pc) + 16'h0001) else $error("not-equal branch");
    slt_taken_a: assert property (acc && req_i.op == OP_BRANCH_SIGNED_LT && nv |=>
        !res_o.done ##1 res_o.done && res_o.taken) else $error("signed less branch");
    sge_fall_a: assert property (acc && req_i.op == OP_BRANCH_SIGNED_GE && nv |=>
        res_o.done && !res_o.taken) else $error("signed ge branch");
    skip_three_a: assert property (acc && req_i.op == OP_SKIP_REG_BIT_SET && req_i.rd[req_i.bit_sel]
        && req_i.two_word |=> !res_o.done [*2] ##1 res_o.done && res_o.pc_next == $past(req_i.pc, 3) + 16'h0003)
        else $error("long skip");
    io_skip_two_a: assert property (acc && req_i.op == OP_SKIP_IO_BIT_CLEAR && !req_i.io[req_i.bit_sel]
        && !req_i.two_word |=> !res_o.done ##1 res_o.done && res_o.pc_next == $past(req_i.pc, 2) + 16'h0002)
        else $error("io skip");
    flags_kept_a: assert property (acc && !is_cmp && !(apb_i.psel && apb_i.pwrite) |=>
        flags_o == $past(flags_o)) else $error("flags changed");

    cover property (acc && req_i.op == OP_CMP_CARRY);
    cover property (res_o.done && res_o.taken);
    cover property (apb_o.pready && apb_o.pslverr);
endmodule
bind csbu_top csbu_top_props u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .ready_o(ready_o), .res_o(res_o), .flags_o(flags_o), .apb_i(apb_i), .apb_o(apb_o));
`default_nettype wire

// ---- verif/csbu_top_tb_top.sv ----
// csbu_top_tb_top: self-checking bench for the compare / skip / branch unit.
// assumes csbu_pkg and csbu_top are compiled first; the bench drives every port.
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module csbu_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csbu_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    csbu_req_t req_i = '0;
    logic ready_o;
    csbu_res_t res_o;
    logic [DATA_W-1:0] flags_o;
    csbu_apb_req_t apb_i = '0;
    csbu_apb_rsp_t apb_o;
    int n_mismatch = 0;
    int checks = 0;
    int mcount = 0;
    logic [7:0] mf = 8'h00;
    logic [31:0] mlast = 32'h0;

    always #2 mclk_i = ~mclk_i;

    csbu_top DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .ready_o(ready_o), .res_o(res_o), .flags_o(flags_o), .apb_i(apb_i), .apb_o(apb_o));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge mclk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge mclk_i);
        apb_i.penable <= 1'b1;
        // no wait count is assumed; only the watchdog ends a wait that never answers
        do @(posedge mclk_i); while (apb_o.pready !== 1'b1);
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i <= '0;
    endtask

    // model first, from the flags before the request, then issue and measure
    task automatic run(input csbu_req_t r);
        int n, ecyc;
        logic [15:0] epc;
        logic cond, c, nv;
        logic [7:0] d;
        cond = 1'b0;
        ecyc = 1;
        epc = r.pc + 16'h0001;
        nv = mf[2] ^ mf[3];
        c = (r.op == OP_CMP_CARRY) ? mf[0] : 1'b0;
        d = r.rd - r.opnd - c;
        case (r.op)
            OP_SKIP_REG_BIT_CLEAR: cond = !r.rd[r.bit_sel];
            OP_SKIP_REG_BIT_SET: cond = r.rd[r.bit_sel];
            OP_SKIP_IO_BIT_CLEAR: cond = !r.io[r.bit_sel];
            OP_SKIP_IO_BIT_SET: cond = r.io[r.bit_sel];
            OP_BRANCH_FLAG_SET: cond = (r.flag_sel == 3'h4) ? nv : mf[r.flag_sel];
            OP_BRANCH_FLAG_CLEAR: cond = !((r.flag_sel == 3'h4) ? nv : mf[r.flag_sel]);
            OP_BRANCH_EQUAL: cond = mf[1];
            OP_BRANCH_NOT_EQUAL: cond = !mf[1];
            OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: cond = mf[0];
            OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: cond = !mf[0];
            OP_BRANCH_MINUS: cond = mf[2];
            OP_BRANCH_PLUS: cond = !mf[2];
            OP_BRANCH_SIGNED_GE: cond = !nv;
            OP_BRANCH_SIGNED_LT: cond = nv;
            default: begin
                mf[1] = (d == 8'h00) && (r.op != OP_CMP_CARRY || mf[1]);
                mf[2] = d[7];
                mf[3] = (r.rd[7] & ~r.opnd[7] & ~d[7]) | (~r.rd[7] & r.opnd[7] & d[7]);
                mf[0] = (~r.rd[7] & r.opnd[7]) | (r.opnd[7] & d[7]) | (d[7] & ~r.rd[7]);
                mf[5] = (~r.rd[3] & r.opnd[3]) | (r.opnd[3] & d[3]) | (d[3] & ~r.rd[3]);
                mf[4] = mf[2] ^ mf[3];
            end
        endcase
        if (cond && r.op <= OP_SKIP_IO_BIT_SET) begin
            ecyc = r.two_word ? 3 : 2;
            epc = r.pc + (r.two_word ? 16'h0003 : 16'h0002);
        end else if (cond) begin
            ecyc = 2;
            epc = r.pc + {{9{r.offs[6]}}, r.offs} + 16'h0001;
        end
        mcount += int'(cond);
        mlast = {13'h0000, 2'(ecyc), cond, epc};
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        do @(posedge mclk_i); while (ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        n = 1;
        #1;
        while (res_o.done !== 1'b1 && n < 6) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        `CHK(n, ecyc)
        `CHK(res_o.pc_next, epc)
        `CHK(res_o.taken, cond)
        `CHK(res_o.pc_load, 1'b1)
        `CHK(flags_o, mf)
    endtask

    initial begin
        csbu_req_t r;
        logic [31:0] rd, v;
        logic err;
        void'($urandom(32'h1299ee48));
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0, rd, err);
        `CHK(rd, 32'h00000001)
        apb(1'b0, 8'h10, 32'h0, rd, err);
        `CHK(err, 1'b1)
        apb(1'b1, REG_CTRL, 32'h0, rd, err);
        #1;
        `CHK(ready_o, 1'b0)
        apb(1'b0, REG_CTRL, 32'h0, rd, err);
        `CHK(rd, 32'h00000000)
        apb(1'b1, REG_CTRL, 32'h1, rd, err);
        #1;
        `CHK(ready_o, 1'b1)
        apb(1'b1, REG_COUNT, 32'h0, rd, err);
        $display("register test done");
        for (int i = 0; i < 400; i++) begin
            if (i % 8 == 0) begin
                v = $urandom;
                apb(1'b1, REG_FLAGS, v, rd, err);
                mf = v[7:0];
            end
            r = 59'({$urandom, $urandom});
            r.op = csbu_op_t'($urandom % 19);
            if ($urandom % 4 == 0)
                r.opnd = r.rd;
            run(r);
        end
        apb(1'b0, REG_COUNT, 32'h0, rd, err);
        `CHK(rd, 32'(mcount))
        apb(1'b0, REG_LAST, 32'h0, rd, err);
        `CHK(rd, mlast)
        $display("instruction test done");
        summarize();
    end

    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire

// ---- verilog/csbu_pkg.sv ----
// csbu_pkg: shared constants and carrier types for the compare / skip / branch unit.
// assumes a 16-bit word-addressed program counter and 8-bit working registers.
`default_nettype none
package csbu_pkg;

    // widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W = 16;
    localparam int unsigned OFFS_W = 7;
    localparam int unsigned CYC_W = 2;

    // status flag bit positions
    localparam logic [2:0] FLG_C = 3'h0;
    localparam logic [2:0] FLG_Z = 3'h1;
    localparam logic [2:0] FLG_N = 3'h2;
    localparam logic [2:0] FLG_V = 3'h3;
    localparam logic [2:0] FLG_S = 3'h4;
    localparam logic [2:0] FLG_H = 3'h5;

    // cycle counts per outcome
    localparam logic [CYC_W-1:0] CYC_CMP = 2'h1;
    localparam logic [CYC_W-1:0] CYC_BR_NOT_TAKEN = 2'h1;
    localparam logic [CYC_W-1:0] CYC_BR_TAKEN = 2'h2;
    localparam logic [CYC_W-1:0] CYC_NO_SKIP = 2'h1;
    localparam logic [CYC_W-1:0] CYC_SKIP_ONE_WORD = 2'h2;
    localparam logic [CYC_W-1:0] CYC_SKIP_TWO_WORD = 2'h3;

    // program counter steps
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_SKIP_ONE_WORD = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP_TWO_WORD = 16'h0003;

    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FLAGS = 8'h04;
    localparam logic [7:0] REG_LAST = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0c;

    // register fields and reset values
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
    localparam int unsigned LAST_TAKEN_BIT = 16;
    localparam int unsigned LAST_CYC_LSB = 17;

    typedef enum logic [4:0] {
        OP_CMP,
        OP_CMP_CARRY,
        OP_CMP_IMM,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR,
        OP_BRANCH_EQUAL,
        OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_SET,
        OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_OR_HIGHER,
        OP_BRANCH_LOWER,
        OP_BRANCH_MINUS,
        OP_BRANCH_PLUS,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT
    } csbu_op_t;

    // request from the instruction decoder; opnd carries Rr or the immediate
    typedef struct packed {
        csbu_op_t op;
        logic [DATA_W-1:0] rd;
        logic [DATA_W-1:0] opnd;
        logic [DATA_W-1:0] io;
        logic [2:0] bit_sel;
        logic [2:0] flag_sel;
        logic [OFFS_W-1:0] offs;
        logic two_word;
        logic [PC_W-1:0] pc;
    } csbu_req_t;

    // result towards the program counter
    typedef struct packed {
        logic done;
        logic pc_load;
        logic taken;
        logic [PC_W-1:0] pc_next;
    } csbu_res_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } csbu_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } csbu_apb_rsp_t;

endpackage
`default_nettype wire

// ---- verilog/csbu_top.sv ----
// csbu_top: executes compares, bit-test skips and conditional relative branches.
// assumes the decoder supplies operand values with the request and holds it until ready_o.
//
// What this block does
// - compare subtracts, discards result, sets ZNVCH, 1 cycle
// - skip when register bit clear, pc+2/3
// - skip when register bit set, pc+2/3
// - skip when I/O bit clear, pc+2/3
// - skip when I/O bit set, pc+2/3
// - branch to pc+k+1 when flag s set
// - branch to pc+k+1 when flag s clear
// - carry set/clear branches test carry flag
// - same-or-higher branch taken when carry clear
// - signed ge taken when N xor V zero
// - signed lt taken when N xor V one
//
// Our own choices: the address map and the APB register port.
`default_nettype none
module csbu_top
    import csbu_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // instruction request from the decoder
    input wire logic req_valid_i,
    input wire csbu_pkg::csbu_req_t req_i,
    output logic ready_o,
    // result towards the program counter and status flags
    output csbu_pkg::csbu_res_t res_o,
    output logic [csbu_pkg::DATA_W-1:0] flags_o,
    // register bus
    input wire csbu_pkg::csbu_apb_req_t apb_i,
    output csbu_pkg::csbu_apb_rsp_t apb_o
);
    import csbu_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } csbu_state_t;

    // selects the tested status bit; S is rebuilt from N and V so stale S never misleads
    function automatic logic flag_bit(input logic [DATA_W-1:0] f, input logic [2:0] sel);
        logic b;
        b = f[sel];
        if (sel == FLG_S) begin
            b = f[FLG_N] ^ f[FLG_V];
        end
        return b;
    endfunction

    // byte-address decode shared by read and write paths
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
        return addr == offs;
    endfunction

    csbu_state_t state_r, state_nxt;
    logic [CYC_W-1:0] remain_r, remain_nxt;
    logic ready_r, ready_nxt;
    csbu_res_t res_r, res_nxt, pend_r, pend_nxt;
    logic [DATA_W-1:0] flags_r, flags_nxt;
    logic ctrl_en_r, ctrl_en_nxt;
    logic [31:0] last_r, last_nxt;
    logic [15:0] count_r, count_nxt;
    csbu_apb_rsp_t apb_r, apb_nxt;

    // request decode
    wire accept = req_valid_i & ready_r;
    wire op_cmp = (req_i.op == OP_CMP) | (req_i.op == OP_CMP_CARRY) | (req_i.op == OP_CMP_IMM);
    wire op_skip = (req_i.op == OP_SKIP_REG_BIT_CLEAR) | (req_i.op == OP_SKIP_REG_BIT_SET) |
                   (req_i.op == OP_SKIP_IO_BIT_CLEAR) | (req_i.op == OP_SKIP_IO_BIT_SET);
    wire op_branch = ~op_cmp & ~op_skip;

    // compare datapath: result is only used for flags
    wire carry_in = (req_i.op == OP_CMP_CARRY) ? flags_r[FLG_C] : 1'b0;
    wire [DATA_W-1:0] sub_a = req_i.rd;
    wire [DATA_W-1:0] sub_b = req_i.opnd;
    wire [DATA_W-1:0] diff = sub_a - sub_b - {7'h00, carry_in};
    wire cmp_h = (~sub_a[3] & sub_b[3]) | (sub_b[3] & diff[3]) | (diff[3] & ~sub_a[3]);
    wire cmp_v = (sub_a[7] & ~sub_b[7] & ~diff[7]) | (~sub_a[7] & sub_b[7] & diff[7]);
    wire cmp_n = diff[7];
    wire cmp_c = (~sub_a[7] & sub_b[7]) | (sub_b[7] & diff[7]) | (diff[7] & ~sub_a[7]);
    // the carry variant keeps Z only if it was already set, so multi-byte compares chain
    wire cmp_z = (diff == 8'h00) & ((req_i.op != OP_CMP_CARRY) | flags_r[FLG_Z]);

    // skip tests
    wire reg_bit = req_i.rd[req_i.bit_sel];
    wire io_bit = req_i.io[req_i.bit_sel];
    wire skip_reg_clr = (req_i.op == OP_SKIP_REG_BIT_CLEAR) & ~reg_bit;
    wire skip_reg_set = (req_i.op == OP_SKIP_REG_BIT_SET) & reg_bit;
    wire skip_io_clr = (req_i.op == OP_SKIP_IO_BIT_CLEAR) & ~io_bit;
    wire skip_io_set = (req_i.op == OP_SKIP_IO_BIT_SET) & io_bit;
    wire do_skip = skip_reg_clr | skip_reg_set | skip_io_clr | skip_io_set;

    // branch conditions
    wire sel_bit = flag_bit(flags_r, req_i.flag_sel);
    wire f_c = flags_r[FLG_C];
    wire f_z = flags_r[FLG_Z];
    wire f_n = flags_r[FLG_N];
    wire f_nv = flag_bit(flags_r, FLG_S);
    logic br_take;

    always_comb begin
        case (req_i.op)
            OP_BRANCH_FLAG_SET: br_take = sel_bit;
            OP_BRANCH_FLAG_CLEAR: br_take = ~sel_bit;
            OP_BRANCH_CARRY_SET: br_take = f_c;
            OP_BRANCH_CARRY_CLEAR: br_take = ~f_c;
            OP_BRANCH_SAME_OR_HIGHER: br_take = ~f_c;
            OP_BRANCH_SIGNED_GE: br_take = ~f_nv;
            OP_BRANCH_SIGNED_LT: br_take = f_nv;
            OP_BRANCH_EQUAL: br_take = f_z;
            OP_BRANCH_NOT_EQUAL: br_take = ~f_z;
            OP_BRANCH_LOWER: br_take = f_c;
            OP_BRANCH_MINUS: br_take = f_n;
            OP_BRANCH_PLUS: br_take = ~f_n;
            default: br_take = 1'b0;
        endcase
    end

    wire taken = (op_branch & br_take) | (op_skip & do_skip);

    // target address; k is a signed word offset
    wire [PC_W-1:0] k_ext = {{(PC_W-OFFS_W){req_i.offs[OFFS_W-1]}}, req_i.offs};
    wire [PC_W-1:0] skip_step = req_i.two_word ? PC_SKIP_TWO_WORD : PC_SKIP_ONE_WORD;
    wire [PC_W-1:0] pc_branch = req_i.pc + k_ext + PC_STEP;
    wire [PC_W-1:0] pc_skip = req_i.pc + skip_step;
    wire [PC_W-1:0] pc_seq = req_i.pc + PC_STEP;
    wire [PC_W-1:0] pc_target = (op_branch & br_take) ? pc_branch : (do_skip ? pc_skip : pc_seq);

    // total cycles of this instruction
    wire [CYC_W-1:0] cyc_skip = req_i.two_word ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD;
    wire [CYC_W-1:0] cyc_total = op_cmp ? CYC_CMP :
                                 op_skip ? (do_skip ? cyc_skip : CYC_NO_SKIP) :
                                 (br_take ? CYC_BR_TAKEN : CYC_BR_NOT_TAKEN);

    // register bus decode
    wire apb_setup = apb_i.psel & ~apb_i.penable;
    wire apb_wr = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_r.pready;
    wire hit_ctrl = reg_hit(apb_i.paddr, REG_CTRL);
    wire hit_flags = reg_hit(apb_i.paddr, REG_FLAGS);
    wire hit_last = reg_hit(apb_i.paddr, REG_LAST);
    wire hit_count = reg_hit(apb_i.paddr, REG_COUNT);
    wire hit_any = hit_ctrl | hit_flags | hit_last | hit_count;
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_en_r} :
                         hit_flags ? {24'h0, flags_r} :
                         hit_last ? last_r :
                         hit_count ? {16'h0, count_r} : 32'h0;

    // sequencing: a one-cycle instruction reports at the accept edge, longer ones later
    always_comb begin
        state_nxt = state_r;
        remain_nxt = remain_r;
        pend_nxt = pend_r;
        res_nxt = res_r;
        res_nxt.done = 1'b0;
        res_nxt.pc_load = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    pend_nxt = '{done: 1'b1, pc_load: 1'b1, taken: taken, pc_next: pc_target};
                    if (cyc_total == CYC_CMP) begin
                        res_nxt = pend_nxt;
                    end else begin
                        state_nxt = ST_BUSY;
                        remain_nxt = CYC_W'(cyc_total - 2'h1);
                    end
                end
            end
            ST_BUSY: begin
                remain_nxt = CYC_W'(remain_r - 2'h1);
                if (remain_r == 2'h1) begin
                    res_nxt = pend_r;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    assign ready_nxt = (state_nxt == ST_IDLE) & ctrl_en_nxt;

    // flags: compare result wins over a bus write in the same cycle; skips and branches leave them
    always_comb begin
        flags_nxt = flags_r;
        if (apb_wr & hit_flags) begin
            flags_nxt = apb_i.pwdata[DATA_W-1:0];
        end
        if (accept & op_cmp) begin
            flags_nxt[FLG_Z] = cmp_z;
            flags_nxt[FLG_N] = cmp_n;
            flags_nxt[FLG_V] = cmp_v;
            flags_nxt[FLG_C] = cmp_c;
            flags_nxt[FLG_H] = cmp_h;
            flags_nxt[FLG_S] = cmp_n ^ cmp_v;
        end
    end

    assign ctrl_en_nxt = (apb_wr & hit_ctrl) ? apb_i.pwdata[CTRL_EN_BIT] : ctrl_en_r;

    // last-outcome record and a count of taken branches and skips
    always_comb begin
        last_nxt = last_r;
        count_nxt = count_r;
        if (accept) begin
            last_nxt = 32'h0;
            last_nxt[PC_W-1:0] = pc_target;
            last_nxt[LAST_TAKEN_BIT] = taken;
            last_nxt[LAST_CYC_LSB +: CYC_W] = cyc_total;
        end
        // a taken event in the clearing cycle still counts, so no outcome is lost
        if (apb_wr & hit_count) begin
            count_nxt = {15'h0000, accept & taken};
        end else if (accept & taken) begin
            count_nxt = 16'(count_r + 16'h0001);
        end
    end

    // bus answer is prepared in the setup cycle, so every access has zero wait states
    always_comb begin
        apb_nxt = '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};
        if (apb_setup) begin
            apb_nxt.pready = 1'b1;
            apb_nxt.pslverr = ~hit_any;
            apb_nxt.prdata = apb_i.pwrite ? 32'h0 : rd_mux;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_IDLE;
            remain_r <= '0;
            ready_r <= 1'b0;
            res_r <= '0;
            pend_r <= '0;
        end else begin
            state_r <= state_nxt;
            remain_r <= remain_nxt;
            ready_r <= ready_nxt;
            res_r <= res_nxt;
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_r <= FLAGS_RST;
            ctrl_en_r <= CTRL_EN_RST;
            last_r <= 32'h0;
            count_r <= 16'h0000;
            apb_r <= '0;
        end else begin
            flags_r <= flags_nxt;
            ctrl_en_r <= ctrl_en_nxt;
            last_r <= last_nxt;
            count_r <= count_nxt;
            apb_r <= apb_nxt;
        end
    end

    assign ready_o = ready_r;
    assign res_o = res_r;
    assign flags_o = flags_r;
    assign apb_o = apb_r;

endmodule
`default_nettype wire
